// ---- core/arrs_top.sv ----
// round-robin scheduler, averaging, limit checks and registers
// assumes the converter returns a stable code by the end of each slot,
// and an Avalon-MM master that holds requests while waitrequest is high
//
// Functional notes
// - Ten supervised channels share one converter through a select index.
// - Selected channels are converted in turn; unselected ones are skipped.
// - A control bit picks one conversion cycle (16 passes with averaging) then stop, or continuous looping.
// - With averaging on, the loop runs 16 passes before a result.
// - Result registers load only when the whole conversion cycle ends.
// - Codes are 12-bit unsigned, zero gives 0, reference gives 4095.
// - One limit per channel, acting as either maximum or minimum check.
// - Limit crossing raises a warning, readable and sent to sequencer.
// - Scan starts on a register write or a sequencer turn-on state.
// - Each selected channel takes about 500 us of conversion time.
// - Live warning status follows results as they update.
// - A held warning copy is captured on every sequencer state change.
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module arrs_top #(
   parameter int SLOT_CYC = arrs_pkg::SLOT_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // register bus
   input  wire logic [7:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWriteData,
   input  wire logic [3:0]  avsByteEnable,
   output logic [31:0]      avsReadData,
   output logic             avsWaitRequest,
   // converter front end
   output logic [3:0]       adcChan,
   output logic             adcStart,
   input  wire logic [11:0] adcCode,
   // sequencing engine
   input  wire logic        seqTurnOn,
   input  wire logic        seqStateChange,
   output logic [9:0]       limitWarn,
   output logic [9:0]       limitHeld,
   // interrupt
   output logic             irq
);
   localparam int TW = arrs_pkg::TMRW;
   localparam int CW = arrs_pkg::CODEW;
   localparam int AW = arrs_pkg::ACCW;

   arrs_pkg::arrs_state_t stateQ;
   logic [3:0]      chIdxQ;
   logic [3:0]      passQ;
   logic [3:0]      lapQ;
   logic [TW-1:0]   timerQ;
   logic            avgRunQ;
   logic            runQ;
   logic            contQ;
   logic            avgQ;
   logic            seqOnQ;
   logic [9:0]      chSelQ;
   logic [9:0]      dirQ;
   logic [9:0]      warnD;
   logic [9:0]      warnQ;
   logic [9:0]      heldQ;
   logic [arrs_pkg::NINT-1:0] intStQ;
   logic [arrs_pkg::NINT-1:0] intMkQ;
   logic [arrs_pkg::NINT-1:0] intSet;
   logic [CW-1:0]   resQ [arrs_pkg::NCH];
   logic [CW-1:0]   limQ [arrs_pkg::NCH];
   logic [AW-1:0]   accQ [arrs_pkg::NCH];
   logic            ackQ;
   logic            wrEn;
   logic [31:0]     rdMux;
   logic [31:0]     rdQ;
   logic [3:0]      regIdx;
   logic            idxOk;
   logic            step;
   logic            lastCh;
   logic            morePass;
   logic            cycleEnd;
   logic            sampleHit;
   logic            runSet;
   logic            irqQ;
   logic            adcStartQ;
   logic [3:0]      adcChanQ;

   // bus slave: one wait cycle, then the answer
   assign avsWaitRequest = (avsRead | avsWrite) & ~ackQ;
   // partial-lane writes are ignored: a write takes effect only with all four byte enables set
   assign wrEn   = avsWrite & ackQ & (avsByteEnable == 4'hF);
   assign regIdx = avsAddress[5:2];
   assign idxOk  = (regIdx <= arrs_pkg::LASTCH) & (avsAddress[1:0] == 2'h0);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ackQ <= 1'b0;
      end else begin
         ackQ <= (avsRead | avsWrite) & ~ackQ;
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      if (avsAddress == arrs_pkg::ADDR_CTRL) begin
         rdMux[arrs_pkg::CTRL_RUN]  = runQ;
         rdMux[arrs_pkg::CTRL_CONT] = contQ;
         rdMux[arrs_pkg::CTRL_AVG]  = avgQ;
         rdMux[arrs_pkg::CTRL_BUSY] = (stateQ != arrs_pkg::ST_IDLE);
      end else if (avsAddress == arrs_pkg::ADDR_CHSEL) begin
         rdMux = 32'(chSelQ);
      end else if (avsAddress == arrs_pkg::ADDR_LIVE) begin
         rdMux = 32'(warnQ);
      end else if (avsAddress == arrs_pkg::ADDR_HELD) begin
         rdMux = 32'(heldQ);
      end else if (avsAddress == arrs_pkg::ADDR_DIR) begin
         rdMux = 32'(dirQ);
      end else if (avsAddress == arrs_pkg::ADDR_INTST) begin
         rdMux = 32'(intStQ);
      end else if (avsAddress == arrs_pkg::ADDR_INTMK) begin
         rdMux = 32'(intMkQ);
      end else if (avsAddress[7:6] == arrs_pkg::WIN_RES && idxOk) begin
         rdMux = 32'(resQ[regIdx]);
      end else if (avsAddress[7:6] == arrs_pkg::WIN_LIM && idxOk) begin
         rdMux = 32'(limQ[regIdx]);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdQ <= 32'h0000_0000;
      end else if (avsRead & ~ackQ) begin
         rdQ <= rdMux;
      end
   end
   assign avsReadData = rdQ;

   // configuration registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         contQ  <= 1'b0;
         avgQ   <= 1'b0;
         chSelQ <= arrs_pkg::CHSEL_RST;
         dirQ   <= 10'h000;
         intMkQ <= '0;
      end else if (wrEn) begin
         if (avsAddress == arrs_pkg::ADDR_CTRL) begin
            contQ <= avsWriteData[arrs_pkg::CTRL_CONT];
            avgQ  <= avsWriteData[arrs_pkg::CTRL_AVG];
         end else if (avsAddress == arrs_pkg::ADDR_CHSEL) begin
            chSelQ <= avsWriteData[9:0];
         end else if (avsAddress == arrs_pkg::ADDR_DIR) begin
            dirQ <= avsWriteData[9:0];
         end else if (avsAddress == arrs_pkg::ADDR_INTMK) begin
            intMkQ <= avsWriteData[arrs_pkg::NINT-1:0];
         end
      end
   end

   // run request: bus write or sequencer turn-on edge; set beats clear
   assign runSet = (wrEn & (avsAddress == arrs_pkg::ADDR_CTRL)
                    & avsWriteData[arrs_pkg::CTRL_RUN])
                   | (seqTurnOn & ~seqOnQ);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         runQ   <= 1'b0;
         seqOnQ <= 1'b0;
      end else begin
         seqOnQ <= seqTurnOn;
         if (runSet) begin
            runQ <= 1'b1;
         end else if (wrEn && avsAddress == arrs_pkg::ADDR_CTRL) begin
            runQ <= 1'b0;
         end else if (cycleEnd && !contQ) begin
            runQ <= 1'b0;
         end
      end
   end

   // scheduler
   assign lastCh   = (chIdxQ == arrs_pkg::LASTCH);
   assign morePass = avgRunQ & (passQ != arrs_pkg::LASTPASS);
   assign sampleHit = (stateQ == arrs_pkg::ST_CONV) && (timerQ == '0);
   assign step = ((stateQ == arrs_pkg::ST_SCAN) && !chSelQ[chIdxQ])
                 | sampleHit;
   assign cycleEnd = step & lastCh & ~morePass;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stateQ  <= arrs_pkg::ST_IDLE;
         chIdxQ  <= arrs_pkg::FIRSTCH;
         passQ   <= arrs_pkg::FIRSTPASS;
         timerQ  <= '0;
         avgRunQ <= 1'b0;
      end else begin
         case (stateQ)
            arrs_pkg::ST_IDLE: begin
               if (runQ && chSelQ != 10'h000) begin
                  stateQ  <= arrs_pkg::ST_SCAN;
                  chIdxQ  <= arrs_pkg::FIRSTCH;
                  passQ   <= arrs_pkg::FIRSTPASS;
                  avgRunQ <= avgQ; // held for the whole cycle
               end
            end
            arrs_pkg::ST_SCAN: begin
               if (chSelQ[chIdxQ]) begin
                  stateQ <= arrs_pkg::ST_CONV;
                  timerQ <= TW'(SLOT_CYC - 1);
               end
            end
            arrs_pkg::ST_CONV: begin
               if (timerQ != '0) begin
                  timerQ <= timerQ - 1'b1;
               end
            end
            default: begin
               stateQ <= arrs_pkg::ST_IDLE;
            end
         endcase
         if (step) begin
            if (!lastCh) begin
               chIdxQ <= chIdxQ + 1'b1;
               stateQ <= arrs_pkg::ST_SCAN;
            end else if (morePass) begin
               passQ  <= passQ + 1'b1;
               chIdxQ <= arrs_pkg::FIRSTCH;
               stateQ <= arrs_pkg::ST_SCAN;
            end else begin
               stateQ <= arrs_pkg::ST_IDLE;
            end
         end
      end
   end

   // converter select and start pulse
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         adcStartQ <= 1'b0;
         adcChanQ  <= arrs_pkg::FIRSTCH;
      end else begin
         adcStartQ <= (stateQ == arrs_pkg::ST_SCAN) && chSelQ[chIdxQ];
         if (stateQ == arrs_pkg::ST_SCAN) begin
            adcChanQ <= chIdxQ;
         end
      end
   end
   assign adcStart = adcStartQ;
   assign adcChan  = adcChanQ;

   // per-channel accumulate, transfer, limit and compare
   for (genvar i = 0; i < arrs_pkg::NCH; i++) begin : g_ch
      logic [AW-1:0] accNext;
      logic [CW-1:0] resNext;
      // unsigned code, zero-extended so 16 full-scale samples fit
      always_comb begin
         accNext = accQ[i];
         if (sampleHit && chIdxQ == 4'(i)) begin
            accNext = (passQ == arrs_pkg::FIRSTPASS) ? AW'(adcCode)
                      : accQ[i] + AW'(adcCode);
         end
         resNext = avgRunQ ? accNext[AW-1:AW-CW] : accNext[CW-1:0];
      end
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            accQ[i] <= '0;
            resQ[i] <= '0;
         end else begin
            accQ[i] <= accNext;
            if (cycleEnd && chSelQ[i]) begin
               resQ[i] <= resNext;
            end
         end
      end
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            limQ[i] <= arrs_pkg::LIM_RST;
         end else if (wrEn && avsAddress[7:6] == arrs_pkg::WIN_LIM
                      && idxOk && regIdx == 4'(i)) begin
            limQ[i] <= avsWriteData[CW-1:0];
         end
      end
      // dir 1: warn above limit, dir 0: warn below limit
      assign warnD[i] = dirQ[i] ? (resQ[i] > limQ[i])
                                : (resQ[i] < limQ[i]);

      a_res_stable: assert property (@(posedge mclk) disable iff (!rstn)
         !cycleEnd |=> $stable(resQ[i]))
         else $error("result changed outside cycle end");
      a_min_quiet: assert property (@(posedge mclk) disable iff (!rstn)
         (!dirQ[i] && resQ[i] >= limQ[i]) |=> !limitWarn[i])
         else $error("min check warned without crossing");
   end

   // live and held warnings
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         warnQ <= 10'h000;
         heldQ <= 10'h000;
      end else begin
         warnQ <= warnD;
         if (seqStateChange) begin
            heldQ <= warnQ;
         end
      end
   end
   assign limitWarn = warnQ;
   assign limitHeld = heldQ;

   // interrupts: sticky, write one to clear, set wins
   always_comb begin
      intSet = '0;
      intSet[arrs_pkg::INT_DONE] = cycleEnd;
      intSet[arrs_pkg::INT_LIM]  = |(warnD & ~warnQ);
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         intStQ <= '0;
         irqQ   <= 1'b0;
      end else begin
         if (wrEn && avsAddress == arrs_pkg::ADDR_INTST) begin
            intStQ <= (intStQ & ~avsWriteData[arrs_pkg::NINT-1:0]) | intSet;
         end else begin
            intStQ <= intStQ | intSet;
         end
         irqQ <= |(intStQ & intMkQ);
      end
   end
   assign irq = irqQ;

   a_chan_range: assert property (@(posedge mclk) disable iff (!rstn)
      adcStart |-> (adcChan <= arrs_pkg::LASTCH))
      else $error("converter channel out of range");
   a_skip_unsel: assert property (@(posedge mclk) disable iff (!rstn)
      (stateQ == arrs_pkg::ST_SCAN && !chSelQ[chIdxQ]) |=> !adcStart)
      else $error("unselected channel converted");
   a_single_stop: assert property (@(posedge mclk) disable iff (!rstn)
      (cycleEnd && !contQ && !runSet) |=> !runQ ##1
      (stateQ == arrs_pkg::ST_IDLE))
      else $error("single pass did not stop");
   // lap count kept apart from passQ so the pass check is independent
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lapQ <= arrs_pkg::FIRSTPASS;
      end else if (stateQ == arrs_pkg::ST_IDLE) begin
         lapQ <= arrs_pkg::FIRSTPASS;
      end else if (step && lastCh) begin
         lapQ <= lapQ + 1'b1;
      end
   end
   a_avg_passes: assert property (@(posedge mclk) disable iff (!rstn)
      cycleEnd |-> (lapQ == (avgRunQ ? arrs_pkg::LASTPASS
                                     : arrs_pkg::FIRSTPASS)))
      else $error("averaged cycle ended early");
   a_seq_start: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(seqTurnOn) |=> runQ)
      else $error("sequencer turn-on did not start scan");
   a_slot_time: assert property (@(posedge mclk) disable iff (!rstn)
      adcStart |-> (stateQ == arrs_pkg::ST_CONV)
      && (timerQ == TW'(SLOT_CYC - 1)))
      else $error("conversion slot not loaded");
   a_held_capt: assert property (@(posedge mclk) disable iff (!rstn)
      seqStateChange |=> (limitHeld == $past(warnQ)))
      else $error("held warnings not captured");
   a_held_keep: assert property (@(posedge mclk) disable iff (!rstn)
      !seqStateChange |=> $stable(limitHeld))
      else $error("held warnings changed between states");
   a_lim_irq: assert property (@(posedge mclk) disable iff (!rstn)
      (|(warnD & ~warnQ)) |=> intStQ[arrs_pkg::INT_LIM])
      else $error("limit event not flagged");
endmodule

// ---- core/arrs_pkg.sv ----
// constants shared by the round-robin converter supervisor
// assumes a 40 MHz system clock and a byte-addressed register bus
package arrs_pkg;
   // channel and code layout
   localparam int         NCH       = 10;
   localparam int         CODEW     = 12;
   localparam int         ACCW      = 16;
   localparam logic [3:0] LASTCH    = 4'h9;
   localparam logic [3:0] LASTPASS  = 4'hF;
   localparam logic [3:0] FIRSTCH   = 4'h0;
   localparam logic [3:0] FIRSTPASS = 4'h0;

   // timing: one conversion slot per selected channel
   localparam int CLK_HZ   = 40_000_000;
   localparam int SLOT_US  = 500;
   localparam int SLOT_CYC = SLOT_US * (CLK_HZ / 1_000_000);
   localparam int TMRW     = 15;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_CHSEL = 8'h04;
   localparam logic [7:0] ADDR_LIVE  = 8'h08;
   localparam logic [7:0] ADDR_HELD  = 8'h0C;
   localparam logic [7:0] ADDR_DIR   = 8'h10;
   localparam logic [7:0] ADDR_INTST = 8'h14;
   localparam logic [7:0] ADDR_INTMK = 8'h18;
   localparam logic [1:0] WIN_RES    = 2'h1;
   localparam logic [1:0] WIN_LIM    = 2'h2;

   // control and interrupt fields
   localparam int CTRL_RUN  = 0;
   localparam int CTRL_CONT = 1;
   localparam int CTRL_AVG  = 2;
   localparam int CTRL_BUSY = 3;
   localparam int INT_DONE  = 0;
   localparam int INT_LIM   = 1;
   localparam int NINT      = 2;

   // reset values
   localparam logic [9:0]  CHSEL_RST = 10'h3FF;
   localparam logic [11:0] LIM_RST   = 12'h000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SCAN = 2'b01,
      ST_CONV = 2'b10
   } arrs_state_t;
endpackage

// ---- test/arrs_conv_model.sv ----
// behavioural converter front end seen by the round-robin supervisor
// assumes adcChan is steady whenever adcStart pulses
`timescale 1ns/1ps
module arrs_conv_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // converter link
   input  wire logic [3:0]  adcChan,
   input  wire logic        adcStart,
   output logic      [11:0] adcCode
);
   logic [3:0]  cntQ [10];
   logic [11:0] base;

   // channel 9 sits near full scale so the top code is reached
   assign base = (adcChan == 4'h9) ? 12'hFF0 : {adcChan, 8'h10};

   // code steps by one per conversion of a channel, so any 16 passes
   // average to base plus 7 whatever count they start from
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cntQ    <= '{default: 4'h0};
         adcCode <= 12'h000;
      end else if (adcStart && adcChan < 4'hA) begin
         cntQ[adcChan] <= cntQ[adcChan] + 4'h1;
         adcCode       <= base + {8'h00, cntQ[adcChan]};
      end
   end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the round-robin converter supervisor
// assumes one wait cycle per bus access and a shortened slot
`timescale 1ns/1ps
module tb_top;
   localparam int SLOT = 8;
   logic        mclk, rstn, avsRead, avsWrite, adcStart;
   logic        seqTurnOn, seqStateChange, avsWaitRequest, irq;
   logic [7:0]  avsAddress;
   logic [31:0] avsWriteData, avsReadData, q, old;
   logic [3:0]  adcChan, avsByteEnable, be;
   logic [11:0] adcCode;
   logic [9:0]  limitWarn, limitHeld;
   logic [3:0]  starts[$];
   logic [3:0]  expCh[3] = '{4'h0, 4'h2, 4'h9};
   int          mismatches, nChecks, cyc, lastCyc;

   arrs_top #(.SLOT_CYC(SLOT)) i_arrs_top (.mclk(mclk), .rstn(rstn),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .adcChan(adcChan), .adcStart(adcStart), .adcCode(adcCode),
      .seqTurnOn(seqTurnOn), .seqStateChange(seqStateChange),
      .limitWarn(limitWarn), .limitHeld(limitHeld), .irq(irq));

   arrs_conv_model i_arrs_conv_model (.mclk(mclk), .rstn(rstn),
      .adcChan(adcChan), .adcStart(adcStart), .adcCode(adcCode));

   always #12.5 mclk = ~mclk;

   task automatic print_verdict();
      if (mismatches == 0 && nChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, e, input string m);
      nChecks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // holds the request until waitrequest is sampled low at an edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avsAddress   <= a;
      avsWriteData <= d;
      avsByteEnable <= be;
      avsWrite     <= w;
      avsRead      <= !w;
      do begin
         @(posedge mclk);
         n++;
      end while (avsWaitRequest !== 1'b0 && n < 20);
      q = avsReadData;
      avsWrite <= 1'b0;
      avsRead  <= 1'b0;
      chk(n < 20, 1, "bus answer");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, e, "read data");
   endtask

   task automatic waitIdle();
      int n;
      n = 0;
      repeat (4) @(posedge mclk);
      do begin
         bus(1'b0, arrs_pkg::ADDR_CTRL, 32'h0000_0000);
         n++;
      end while (q[arrs_pkg::CTRL_BUSY] !== 1'b0 && n < 400);
      chk(q[arrs_pkg::CTRL_BUSY], 1'b0, "scan idle");
   endtask

   task automatic waitStarts(input int k);
      int n;
      n = 0;
      while (starts.size() < k && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      chk(starts.size() >= k, 1, "start count");
   endtask

   // a hang ends the run as a failure
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         print_verdict();
      end
   end

   always @(posedge mclk) begin
      if (adcStart === 1'b1) begin
         if (starts.size() > 0)
            chk(cyc - lastCyc >= SLOT, 1, "slot length");
         starts.push_back(adcChan);
         lastCyc = cyc;
      end
   end

   initial begin
      mclk           = 1'b0;
      rstn           = 1'b0;
      avsRead        = 1'b0;
      avsWrite       = 1'b0;
      avsAddress     = 8'h00;
      avsWriteData   = 32'h0000_0000;
      avsByteEnable  = 4'hF;
      be             = 4'hF;
      seqTurnOn      = 1'b0;
      seqStateChange = 1'b0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rd(arrs_pkg::ADDR_CTRL, 32'h0000_0000);
      rd(arrs_pkg::ADDR_CHSEL, 32'h0000_03FF);
      rd(8'h30, 32'h0000_0000);
      // a partial-lane write must leave the selection alone
      be = 4'h1;
      wr(arrs_pkg::ADDR_CHSEL, 32'h0000_0001);
      be = 4'hF;
      rd(arrs_pkg::ADDR_CHSEL, 32'h0000_03FF);
      wr(arrs_pkg::ADDR_CHSEL, 32'h0000_0205);
      wr(arrs_pkg::ADDR_DIR, 32'h0000_0004);
      wr(8'h80, 32'h0000_0020);
      wr(8'h88, 32'h0000_0200);
      wr(arrs_pkg::ADDR_CTRL, 32'h0000_0001);
      waitIdle();
      chk(starts.size(), 3, "single pass count");
      for (int i = 0; i < 3; i++)
         chk(starts[i], expCh[i], "channel order");
      rd(8'h40, 32'h0000_0010);
      rd(8'h44, 32'h0000_0000);
      rd(8'h48, 32'h0000_0210);
      rd(8'h64, 32'h0000_0FF0);
      rd(arrs_pkg::ADDR_LIVE, 32'h0000_0005);
      chk(limitWarn, 10'h005, "live warnings");
      rd(arrs_pkg::ADDR_INTST, 32'h0000_0003);
      chk(irq, 1'b0, "masked irq");
      wr(arrs_pkg::ADDR_INTMK, 32'h0000_0003);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b1, "unmasked irq");
      wr(arrs_pkg::ADDR_INTST, 32'h0000_0003);
      rd(arrs_pkg::ADDR_INTST, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0, "cleared irq");
      seqStateChange <= 1'b1;
      @(posedge mclk);
      seqStateChange <= 1'b0;
      @(posedge mclk);
      chk(limitHeld, 10'h005, "held warnings");
      rd(arrs_pkg::ADDR_HELD, 32'h0000_0005);
      starts.delete();
      wr(arrs_pkg::ADDR_CTRL, 32'h0000_0003);
      waitStarts(7);
      // the stop lands inside the third loop, which still completes
      wr(arrs_pkg::ADDR_CTRL, 32'h0000_0000);
      waitIdle();
      chk(starts.size(), 9, "loop repeats");
      bus(1'b0, 8'h40, 32'h0000_0000);
      old = q;
      wr(8'h80, 32'h0000_0015);
      wr(arrs_pkg::ADDR_CTRL, 32'h0000_0004);
      starts.delete();
      seqTurnOn <= 1'b1;
      waitStarts(4);
      rd(8'h40, old);
      waitIdle();
      seqTurnOn <= 1'b0;
      chk(starts.size(), 48, "averaged passes");
      rd(8'h40, 32'h0000_0017);
      rd(8'h48, 32'h0000_0217);
      rd(8'h64, 32'h0000_0FF7);
      rd(arrs_pkg::ADDR_LIVE, 32'h0000_0004);
      print_verdict();
   end
endmodule
